// [hw/lpci_top.v]
// Panel configuration register, digit intensity and multiplex staggering
`default_nettype none
// Function
// [RULE1] D6 selects mono/RGB or red-green-yellow
// [RULE2] No-colour variant holds D6 at zero
// [RULE3] D7 clear gives four on/off planes
// [RULE4] D7 set gives two four-level planes
// [RULE5] Configuration bit layout D7 to D2
// [RULE6] Arithmetic graduation frame patterns
// [RULE7] Geometric graduation frame patterns
// [RULE8] Digit 0 intensity register at 0x03
// [RULE9] Digit 1 intensity register at 0x04
// [RULE10] Current plane bits read only
// [RULE11] Ripple sync offsets timing by four clocks
// [RULE12] 256 drivers give 244 us total offset
// [RULE13] Mux flip reverses timing on alternates
// [RULE14] Host picks monocolour for RGB panels
// [RULE15] Plane code depends on D7
// [RULE16] Even addresses normal, odd addresses flipped
// [RULE17] Digit duty is n/256 of panel
// [RULE18] Graduation chosen per digit
// [RULE19] Frame index counts 0 to 11
module lpci_top #(
   parameter HAS_COLOUR = 1,
   parameter HAS_LEVELS = 1
) (
   input  wire       core_clk,
   input  wire       rst,
   input  wire       clk_en,
   input  wire       reg_wr,
   input  wire       reg_rd,
   input  wire [7:0] reg_addr,
   input  wire [7:0] reg_wdata,
   output reg  [7:0] reg_rdata,
   input  wire [7:0] driver_addr,
   input  wire [1:0] active_plane,
   input  wire       sync_in,
   input  wire [7:0] panel_level,
   input  wire [1:0] pixel_scale,
   input  wire [1:0] pixel_code0,
   input  wire [1:0] pixel_code1,
   input  wire       frame_tick,
   output wire       colour_rgy,
   output wire       planes_levels_select,
   output reg        sync_out,
   output reg  [7:0] mux_phase,
   output wire       digit0_lit,
   output wire       digit1_lit
);
   `include "lpci_defs.vh"
   // ==============================
   // Registers
   reg  [7:0] digit0_intensity;
   reg  [7:0] digit1_intensity;
   reg        cfg_planes;
   reg        cfg_colour;
   reg        cfg_flip;
   reg        cfg_ripple;
   reg  [3:0] frame_index;
   reg  [1:0] ripple_cnt;
   reg        ripple_busy;
   reg  [7:0] phase;
   reg        sync_meta;
   reg        sync_q;
   reg        sync_q_d;
   wire       sync_rise;
   wire       has_colour;
   wire       has_levels;
   wire       active_plane_hi;
   wire       active_plane_lo;
   wire [7:0] cfg_read;
   assign planes_levels_select = cfg_planes;
   // Cut-down variants tie these bits low and drop whatever is written to them
   assign has_colour = (HAS_COLOUR != 0);
   assign has_levels = (HAS_LEVELS != 0);
   assign colour_rgy = cfg_colour;                               // see [RULE1]
   // Plane code: in two-plane mode planes 0 and 1 read as 10 and 11
   assign active_plane_hi = cfg_planes | active_plane[1];        // see [RULE15]
   assign active_plane_lo = active_plane[0];
   assign cfg_read = {cfg_planes, cfg_colour, cfg_flip, cfg_ripple,
                      active_plane_hi, active_plane_lo, 2'b00};  // see [RULE5]
   // ==============================
   // Register write
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         digit0_intensity <= `LPCI_DIG_RESET;
         digit1_intensity <= `LPCI_DIG_RESET;
         cfg_planes <= 1'b0;
         cfg_colour <= 1'b0;
         cfg_flip <= 1'b0;
         cfg_ripple <= 1'b0;
      end else if (clk_en && reg_wr) begin
         if (reg_addr == `LPCI_ADDR_DIG0) begin
            digit0_intensity <= reg_wdata;                       // see [RULE8]
         end else if (reg_addr == `LPCI_ADDR_DIG1) begin
            digit1_intensity <= reg_wdata;                       // see [RULE9]
         end else if (reg_addr == `LPCI_ADDR_CFG) begin          // see [RULE10]
            // Plane bits D3:D2 are not stored; writes to them vanish
            cfg_planes <= has_levels & reg_wdata[`LPCI_CFG_PLANES_BIT]; // see [RULE3] [RULE4]
            cfg_colour <= has_colour & reg_wdata[`LPCI_CFG_COLOUR_BIT]; // see [RULE2]
            cfg_flip <= reg_wdata[`LPCI_CFG_FLIP_BIT];
            cfg_ripple <= reg_wdata[`LPCI_CFG_RIPPLE_BIT];
         end
      end
   end
   // ==============================
   // Register read: unmapped addresses read as zero
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (clk_en && reg_rd) begin
         if (reg_addr == `LPCI_ADDR_DIG0) begin
            reg_rdata <= digit0_intensity;
         end else if (reg_addr == `LPCI_ADDR_DIG1) begin
            reg_rdata <= digit1_intensity;
         end else if (reg_addr == `LPCI_ADDR_CFG) begin
            reg_rdata <= cfg_read;
         end else begin
            reg_rdata <= 8'h00;
         end
      end
   end
   // ==============================
   // Frame index
   // Wraps after the twelfth frame so every pattern restarts on frame zero
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         frame_index <= 4'h0;
      end else if (clk_en && frame_tick) begin
         frame_index <= (frame_index == `LPCI_FRAME_LAST) ? 4'h0
                        : frame_index + 4'h1;                    // see [RULE19]
      end
   end
   // ==============================
   // Multiplex sync: the chain resyncs on sync_in from the previous driver
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sync_meta <= 1'b0;
         sync_q <= 1'b0;
         sync_q_d <= 1'b0;
      end else if (clk_en) begin
         sync_meta <= sync_in;
         sync_q <= sync_meta;
         sync_q_d <= sync_q;
      end
   end
   // Act once per incoming pulse, however long the previous driver holds it
   assign sync_rise = sync_q & ~sync_q_d;
   // Ripple delays the passed-on sync four clocks per driver, so 256 drivers
   // stagger by about 244 us at the nominal oscillator, too short to see
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ripple_cnt <= 2'h0;
         ripple_busy <= 1'b0;
         sync_out <= 1'b0;
         phase <= 8'h00;
      end else if (clk_en) begin
         sync_out <= 1'b0;
         if (sync_rise && !ripple_busy) begin
            // Phase restarts on each accepted sync so chained drivers stay aligned
            phase <= 8'h00;
            if (cfg_ripple) begin
               ripple_busy <= 1'b1;                              // see [RULE11]
               ripple_cnt <= 2'h0;
            end else begin
               sync_out <= 1'b1;
            end
         end else begin
            phase <= phase + 8'h01;
            if (ripple_busy) begin
               ripple_cnt <= ripple_cnt + 2'h1;
               if (ripple_cnt == `LPCI_RIPPLE_DIV) begin
                  ripple_busy <= 1'b0;
                  sync_out <= 1'b1;                              // see [RULE12]
               end
            end
         end
      end
   end
   // ==============================
   // Mux phase
   // With the flip bit set, odd drivers run the phase backwards to spread supply current peaks
   // Inverted phase puts an odd driver's on-time at the end of its period
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         mux_phase <= 8'h00;
      end else if (clk_en) begin
         mux_phase <= (cfg_flip && driver_addr[0]) ? ~phase : phase; // see [RULE13] [RULE16]
      end
   end
   // ==============================
   // Digit outputs
   // Both digits share one phase, so their on-times start together, or end together when an odd driver's phase is inverted
   lpci_digit_pwm #(.W(8)) u_dig0 (
      .core_clk     (core_clk),
      .rst          (rst),
      .clk_en       (clk_en),
      .pwm_phase    (mux_phase),
      .panel_level  (panel_level),
      .digit_level  (digit0_intensity),
      .frame_index  (frame_index),
      .geometric    (pixel_scale[0]),
      .two_bit_mode (cfg_planes),
      .pixel_code   (pixel_code0),
      .lit          (digit0_lit)
   );
   lpci_digit_pwm #(.W(8)) u_dig1 (
      .core_clk     (core_clk),
      .rst          (rst),
      .clk_en       (clk_en),
      .pwm_phase    (mux_phase),
      .panel_level  (panel_level),
      .digit_level  (digit1_intensity),
      .frame_index  (frame_index),
      .geometric    (pixel_scale[1]),
      .two_bit_mode (cfg_planes),
      .pixel_code   (pixel_code1),
      .lit          (digit1_lit)
   );
endmodule
`default_nettype wire

// [hw/lpci_defs.vh]
// Constants for the panel configuration and intensity block
`ifndef LPCI_DEFS_VH
`define LPCI_DEFS_VH
`define LPCI_ADDR_DIG0        8'h03
`define LPCI_ADDR_DIG1        8'h04
`define LPCI_ADDR_CFG         8'h0D
`define LPCI_CFG_PLANES_BIT   7
`define LPCI_CFG_COLOUR_BIT   6
`define LPCI_CFG_FLIP_BIT     5
`define LPCI_CFG_RIPPLE_BIT   4
`define LPCI_CFG_PLANE_HI     3
`define LPCI_CFG_PLANE_LO     2
`define LPCI_CFG_RESET        8'h00
`define LPCI_DIG_RESET        8'hFF
`define LPCI_FRAME_LAST       4'hB
`define LPCI_ARITH_HI_PAT     12'hB6D
`define LPCI_ARITH_LO_PAT     12'h492
`define LPCI_GEOM_HI_PAT      12'h555
`define LPCI_GEOM_LO_PAT      12'h222
`define LPCI_RIPPLE_DIV       2'h3
`endif

// [hw/lpci_digit_pwm.v]
// Per-digit PWM and 2-bit pixel frame modulation
`default_nettype none
module lpci_digit_pwm #(
   parameter W = 8
) (
   input  wire         core_clk,
   input  wire         rst,
   input  wire         clk_en,
   input  wire [W-1:0] pwm_phase,
   input  wire [W-1:0] panel_level,
   input  wire [W-1:0] digit_level,
   input  wire [3:0]   frame_index,
   input  wire         geometric,
   input  wire         two_bit_mode,
   input  wire [1:0]   pixel_code,
   output reg          lit
);
   `include "lpci_defs.vh"
   // ==============================
   // Duty is n/256 of panel level
   wire [2*W-1:0] product = panel_level * digit_level;            // see [RULE17]
   wire [W-1:0]   duty    = product[2*W-1:W];
   reg  [11:0]    pat;
   reg            frame_on;
   always @* begin
      if (geometric) begin                                        // see [RULE18]
         pat = pixel_code[1] ? `LPCI_GEOM_HI_PAT : `LPCI_GEOM_LO_PAT;   // see [RULE7]
      end else begin
         pat = pixel_code[1] ? `LPCI_ARITH_HI_PAT : `LPCI_ARITH_LO_PAT; // see [RULE6]
      end
      if (!two_bit_mode) begin
         frame_on = pixel_code[0];
      end else if (pixel_code == 2'b11) begin
         frame_on = 1'b1;
      end else if (pixel_code == 2'b00) begin
         frame_on = 1'b0;
      end else begin
         frame_on = pat[frame_index];
      end
   end
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         lit <= 1'b0;
      end else if (clk_en) begin
         lit <= frame_on & (pwm_phase < duty);
      end
   end
endmodule
`default_nettype wire

// [testbench/lpci_top_sva.sv]
// Port checker for the configuration and intensity block
`default_nettype none
module lpci_top_sva #(
   parameter HAS_COLOUR = 1,
   parameter HAS_LEVELS = 1
) (
   input wire logic       core_clk,
   input wire logic       rst,
   input wire logic       clk_en,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic [1:0] active_plane,
   input wire logic       sync_in,
   input wire logic       colour_rgy,
   input wire logic       planes_levels_select,
   input wire logic       sync_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================
   // Shadow of the ripple bit, not visible at the ports
   logic rip;
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (rst);
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) rip <= 1'b0;
      else if (clk_en && reg_wr && reg_addr == 8'h0D) rip <= reg_wdata[4];
   end
   sequence cfg_rd;
      clk_en && reg_rd && reg_addr == 8'h0D;
   endsequence
   sequence cfg_wr;
      clk_en && reg_wr && reg_addr == 8'h0D;
   endsequence
   sequence sync_rise;
      clk_en && $rose(sync_in);
   endsequence
   cfg_low_zero_a: assert property (cfg_rd |=> reg_rdata[1:0] == 2'h0)
      else $error("low config bits not zero");
   plane_code_a: assert property (
      cfg_rd |=> reg_rdata[3:2] == ($past(planes_levels_select) ?
         {1'b1, $past(active_plane[0])} : $past(active_plane)))
      else $error("plane code wrong");
   colour_wr_a: assert property (
      cfg_wr |=> colour_rgy == (HAS_COLOUR != 0 && $past(reg_wdata[6])))
      else $error("colour bit wrong");
   planes_wr_a: assert property (
      cfg_wr |=> planes_levels_select == (HAS_LEVELS != 0 && $past(reg_wdata[7])))
      else $error("planes bit wrong");
   unmapped_zero_a: assert property (
      clk_en && reg_rd && !(reg_addr inside {8'h03, 8'h04, 8'h0D}) |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   sync_pulse_a: assert property (sync_out |=> !sync_out)
      else $error("sync pulse too long");
   ripple_off_a: assert property (sync_rise ##0 !rip |-> ##[2:4] sync_out)
      else $error("unstaggered sync late");
   ripple_on_a: assert property (sync_rise ##0 rip |-> ##[6:9] sync_out)
      else $error("staggered sync late");
endmodule
bind lpci_top lpci_top_sva #(.HAS_COLOUR(HAS_COLOUR), .HAS_LEVELS(HAS_LEVELS)) i_sva (.*);
`default_nettype wire

// [testbench/lpci_host.sv]
// Host model driving the register port
`default_nettype none
module lpci_host (
   input  wire logic       core_clk,
   output var  logic       reg_wr,
   output var  logic       reg_rd,
   output var  logic [7:0] reg_addr,
   output var  logic [7:0] reg_wdata,
   input  wire logic [7:0] reg_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
   // ==========================================
   // Strobes rise after one edge and drop after the taking edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      #1 {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
      @(posedge core_clk);
      #1 reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      #1 {reg_rd, reg_addr} = {1'b1, a};
      @(posedge core_clk);
      #1 reg_rd = 1'b0;
      d = reg_rdata;
   endtask
endmodule
`default_nettype wire

// [testbench/led_panel_config_intensity_bench.sv]
// Self-checking bench for the configuration and intensity block
`default_nettype none
`include "lpci_defs.vh"
module led_panel_config_intensity_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic       core_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, sync_in = 1'b0, frame_tick = 1'b0;
   logic       reg_wr, reg_rd, colour_rgy, planes_levels_select, sync_out, digit0_lit, digit1_lit;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, mux_phase;
   logic [7:0] driver_addr = 8'h00, panel_level = 8'hFF;
   logic [1:0] active_plane = 2'h3, pixel_scale = 2'h2, pixel_code0 = 2'h0, pixel_code1 = 2'h0;
   logic [7:0] fx_rdata;
   logic       fx_colour, fx_planes;
   int         errors = 0, check_count = 0, cycles = 0;
   lpci_top i_dut (.*);
   lpci_host i_host (.*);
   // Variant without colour or level options; its read port is checked too
   lpci_top #(.HAS_COLOUR(0), .HAS_LEVELS(0)) i_dut_fixed (
      .core_clk             (core_clk),
      .rst                  (rst),
      .clk_en               (clk_en),
      .reg_wr               (reg_wr),
      .reg_rd               (reg_rd),
      .reg_addr             (reg_addr),
      .reg_wdata            (reg_wdata),
      .reg_rdata            (fx_rdata),
      .driver_addr          (driver_addr),
      .active_plane         (active_plane),
      .sync_in              (sync_in),
      .panel_level          (panel_level),
      .pixel_scale          (pixel_scale),
      .pixel_code0          (pixel_code0),
      .pixel_code1          (pixel_code1),
      .frame_tick           (frame_tick),
      .colour_rgy           (fx_colour),
      .planes_levels_select (fx_planes),
      .sync_out             (),
      .mux_phase            (),
      .digit0_lit           (),
      .digit1_lit           ()
   );
   initial forever #50 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         errors++;
         print_verdict();
      end
   end
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      check_count++;
      if (g !== e) begin
         errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic print_verdict();
      $display("errors=%0d checks=%0d", errors, check_count);
      if (errors == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // ==========================================
   task automatic t_regs();
      logic [7:0] d;
      i_host.rd(`LPCI_ADDR_DIG0, d);
      chk(d, `LPCI_DIG_RESET);
      i_host.wr(`LPCI_ADDR_DIG0, 8'h5A);
      i_host.wr(`LPCI_ADDR_DIG1, 8'hA5);
      i_host.wr(8'h05, 8'h00);
      i_host.rd(`LPCI_ADDR_DIG1, d);
      chk(d, 8'hA5);
      i_host.rd(`LPCI_ADDR_DIG0, d);
      chk(d, 8'h5A);
      i_host.rd(8'h05, d);
      chk(d, 8'h00);
      i_host.wr(`LPCI_ADDR_CFG, 8'hFF);
      i_host.rd(`LPCI_ADDR_CFG, d);
      chk(d, 8'hFC);
      chk(fx_rdata, 8'h3C);
      chk({fx_colour, fx_planes}, 8'h00);
      active_plane = 2'h2;
      i_host.rd(`LPCI_ADDR_CFG, d);
      chk(d, 8'hF8);
      chk(fx_rdata, 8'h38);
      chk({colour_rgy, planes_levels_select}, 8'h03);
      i_host.wr(`LPCI_ADDR_CFG, 8'h00);
      i_host.rd(`LPCI_ADDR_CFG, d);
      chk(d, 8'h08);
      chk({colour_rgy, planes_levels_select}, 8'h00);
   endtask
   task automatic sync_delay(output int n);
      sync_in = 1'b1;
      n = 0;
      @(posedge core_clk);
      #1 sync_in = 1'b0;
      while (sync_out !== 1'b1 && n < 20) begin
         @(posedge core_clk);
         #1 n++;
      end
   endtask
   task automatic t_sync();
      int a, b;
      sync_delay(a);
      i_host.wr(`LPCI_ADDR_CFG, 8'h10);
      sync_delay(b);
      chk(8'(b - a), 8'h04);
   endtask
   task automatic t_flip();
      logic [7:0] a;
      i_host.wr(`LPCI_ADDR_CFG, 8'h00);
      driver_addr = 8'h03;
      @(posedge core_clk);
      #1 a = mux_phase;
      @(posedge core_clk);
      #1 chk(mux_phase, a + 8'h01);
      i_host.wr(`LPCI_ADDR_CFG, 8'h20);
      driver_addr = 8'h02;
      @(posedge core_clk);
      #1 a = mux_phase;
      driver_addr = 8'h03;
      @(posedge core_clk);
      #1 chk(~mux_phase, a + 8'h01);
   endtask
   task automatic t_frames();
      logic [11:0] p0, p1;
      logic        s0, s1;
      i_host.wr(`LPCI_ADDR_DIG0, 8'hFF);
      i_host.wr(`LPCI_ADDR_DIG1, 8'hFF);
      i_host.wr(`LPCI_ADDR_CFG, 8'h80);
      for (int k = 0; k < 24; k++) begin
         p0 = (k < 12) ? `LPCI_ARITH_HI_PAT : `LPCI_ARITH_LO_PAT;
         p1 = (k < 12) ? `LPCI_GEOM_HI_PAT : `LPCI_GEOM_LO_PAT;
         pixel_code0 = (k < 12) ? 2'h2 : 2'h1;
         pixel_code1 = pixel_code0;
         frame_tick = (k > 0);
         @(posedge core_clk);
         #1 frame_tick = 1'b0;
         {s0, s1} = 2'h0;
         repeat (6) begin
            @(posedge core_clk);
            #1 {s0, s1} = {s0 | digit0_lit, s1 | digit1_lit};
         end
         chk({s1, s0}, {p1[k % 12], p0[k % 12]});
      end
   endtask
   // One full phase period counts the lit cycles: panel 0x80 times 0x80/256
   task automatic t_duty();
      int n0, n1;
      n0 = 0;
      n1 = 0;
      i_host.wr(`LPCI_ADDR_CFG, 8'h00);
      i_host.wr(`LPCI_ADDR_DIG0, 8'h80);
      panel_level = 8'h80;
      pixel_code0 = 2'h1;
      pixel_code1 = 2'h2;
      repeat (2) @(posedge core_clk);
      repeat (256) begin
         @(posedge core_clk);
         #1 n0 += digit0_lit;
         n1 += digit1_lit;
      end
      chk(8'(n0), 8'h40);
      chk(8'(n1), 8'h00);
   endtask
   initial begin
      repeat (4) @(posedge core_clk);
      #1 rst = 1'b0;
      t_regs();
      t_sync();
      t_flip();
      t_frames();
      t_duty();
      print_verdict();
   end
endmodule
`default_nettype wire
